// ===== rtl/buck_ctrl_bank.sv
// Control register bank of a multi-phase step-down converter
// Assumes a synchronous byte register port from the serial interface
// What this block does
// - Writing restore bit one then zero reloads all registers except the fault flags to defaults
// - After restore, rail keeps regulating on new values while enable high
// - Restore leaves fault flags untouched
// - Flags clear only by writing zero or power-up, not by read or restore
// - On enable rise, wait delay code times 100 us, then rail on
// - On enable fall, wait delay code times 100 us, then rail off
// - Delay code all ones keeps the rail off always
// - Writing all ones while running powers down at once
// - Read-only ID: part bit, five-bit fuse version, two-bit die revision
// - Three-bit entry code selects light-load entry current 50 to 325 mA
// - Three-bit exit code, default 101, selects exit current 100 to 375 mA
// - Phase-add code, default 100, 0.3-1.0 A per phase times phases
// - Phase-drop code, default 010, same scale, drops a phase below it
`timescale 1ns/10ps
`include "buck_cfg.svh"
module buck_ctrl_bank #(
  parameter int         STEP_CYCLES = `STEP_CYCLES,
  parameter logic       PART_CODE   = 1'b0,   // Arbitrary value
  parameter logic [4:0] FUSE_VER    = 5'h0a,  // Arbitrary value
  parameter logic [1:0] SILICON_REVISION_FIELD     = 2'h2,   // Arbitrary value
  parameter logic [2:0] PHASES      = 3'h6
) (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        RAIL_ENABLE_PIN,
  input  wire logic [2:0]  ACTIVE_PHASES,
  input  wire logic [7:0]  FAULT_SET,
  output logic      [7:0]  FAULT_FLAGS,
  output logic             RAIL_ON,
  output logic      [8:0]  ENTRY_MA,
  output logic      [8:0]  EXIT_MA,
  output logic      [12:0] ADD_MA,
  output logic      [12:0] DROP_MA
);
  // ==========================================================
  // Parameter checks
  if (PHASES == 3'h0 || PHASES > 3'h6) begin : g_bad_phases
    $error("PHASES out of range");
  end
  if (STEP_CYCLES < 2 || STEP_CYCLES > 65535) begin : g_bad_step
    $error("STEP_CYCLES out of range");
  end
  localparam buck_pkg::reg_byte_t ID_WORD = {PART_CODE, FUSE_VER, SILICON_REVISION_FIELD};

  // ==========================================================
  // Register write decode
  buck_pkg::reg_byte_t restore_reg;
  buck_pkg::reg_byte_t rail_delay_code_reg;
  buck_pkg::reg_byte_t light_load_reg;
  buck_pkg::reg_byte_t phase_reg;
  buck_pkg::reg_byte_t flags_reg;
  logic soft_restore;
  logic wr_restore;
  logic wr_delay;
  logic wr_light_load;
  logic wr_phase;
  logic wr_flags;

  // Write strobe for one register offset
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] offset);
    wr_hit = wr && (addr == offset);
  endfunction

  assign wr_restore    = wr_hit(REG_WR, REG_ADDR, `OFF_RESTORE);
  assign wr_delay      = wr_hit(REG_WR, REG_ADDR, `OFF_RAIL_DELAY);
  assign wr_light_load = wr_hit(REG_WR, REG_ADDR, `OFF_LIGHT_LOAD);
  assign wr_phase      = wr_hit(REG_WR, REG_ADDR, `OFF_PHASE);
  assign wr_flags      = wr_hit(REG_WR, REG_ADDR, `OFF_FLAGS);
  assign soft_restore  = wr_restore && restore_reg[`RESTORE_BIT] &&
                         !REG_WDATA[`RESTORE_BIT];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      restore_reg <= `RST_RESTORE;
    end else if (soft_restore) begin
      restore_reg <= `RST_RESTORE;
    end else if (wr_restore) begin
      restore_reg <= REG_WDATA;
    end
  end

  // ==========================================================
  // Rail delay code
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rail_delay_code_reg <= `RST_RAIL_DELAY;
    end else if (soft_restore) begin
      rail_delay_code_reg <= `RST_RAIL_DELAY;
    end else if (wr_delay) begin
      rail_delay_code_reg <= REG_WDATA;
    end
  end

  // ==========================================================
  // Light-load codes, reserved bits held at zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      light_load_reg <= `RST_LIGHT_LOAD;
    end else if (soft_restore) begin
      light_load_reg <= `RST_LIGHT_LOAD;
    end else if (wr_light_load) begin
      light_load_reg <= REG_WDATA & `FIELD_MASK;
    end
  end

  // ==========================================================
  // Phase codes, reserved bits held at zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase_reg <= `RST_PHASE;
    end else if (soft_restore) begin
      phase_reg <= `RST_PHASE;
    end else if (wr_phase) begin
      phase_reg <= REG_WDATA & `FIELD_MASK;
    end
  end

  // ==========================================================
  // Fault flags: hardware set beats software clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flags_reg <= 8'h00;
    end else if (wr_flags) begin
      flags_reg <= (flags_reg & REG_WDATA) | FAULT_SET;
    end else begin
      flags_reg <= flags_reg | FAULT_SET;
    end
  end
  assign FAULT_FLAGS = flags_reg;

  // ==========================================================
  // Rail sequencing
  buck_pkg::rail_state_e state_reg;
  logic       en_prev_reg;
  logic       en_change;
  logic       tick;
  logic [7:0] steps_reg;
  logic       never_on;
  logic       done;

  assign en_change = RAIL_ENABLE_PIN != en_prev_reg;
  assign never_on  = rail_delay_code_reg == `DELAY_NEVER;
  assign done      = steps_reg >= rail_delay_code_reg;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      en_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= RAIL_ENABLE_PIN;
    end
  end

  step_tick #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_tick (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .restart (en_change),
    .tick    (tick)
  );

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      steps_reg <= 8'h00;
    end else if (en_change) begin
      steps_reg <= 8'h00;
    end else if (tick && !done) begin
      steps_reg <= steps_reg + 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= buck_pkg::RAIL_OFF;
    end else if (never_on) begin
      state_reg <= buck_pkg::RAIL_OFF;
    end else begin
      unique case (state_reg)
        buck_pkg::RAIL_OFF: begin
          if (RAIL_ENABLE_PIN) begin
            state_reg <= buck_pkg::RAIL_WAKE;
          end
        end
        buck_pkg::RAIL_WAKE: begin
          if (!RAIL_ENABLE_PIN) begin
            state_reg <= buck_pkg::RAIL_OFF;
          end else if (done && !en_change) begin
            state_reg <= buck_pkg::RAIL_ON;
          end
        end
        buck_pkg::RAIL_ON: begin
          if (!RAIL_ENABLE_PIN) begin
            state_reg <= buck_pkg::RAIL_SLEEP;
          end
        end
        buck_pkg::RAIL_SLEEP: begin
          if (RAIL_ENABLE_PIN) begin
            state_reg <= buck_pkg::RAIL_ON;
          end else if (done && !en_change) begin
            state_reg <= buck_pkg::RAIL_OFF;
          end
        end
      endcase
    end
  end

  assign RAIL_ON = (state_reg == buck_pkg::RAIL_ON) ||
                   (state_reg == buck_pkg::RAIL_SLEEP);

  // ==========================================================
  // Thresholds
  // Active phase count, kept inside what the converter has
  logic [2:0] phases_eff;
  always_comb begin
    if (ACTIVE_PHASES == 3'h0) begin
      phases_eff = 3'h1;
    end else if (ACTIVE_PHASES > PHASES) begin
      phases_eff = PHASES;
    end else begin
      phases_eff = ACTIVE_PHASES;
    end
  end

  thr_if thr ();
  assign thr.entry_code = light_load_reg[`ENTRY_MSB:`ENTRY_LSB];
  assign thr.exit_code  = light_load_reg[`EXIT_MSB:`EXIT_LSB];
  assign thr.add_code   = phase_reg[`ENTRY_MSB:`ENTRY_LSB];
  assign thr.drop_code  = phase_reg[`EXIT_MSB:`EXIT_LSB];
  assign thr.phases     = phases_eff;

  thr_decode u_dec (
    .t (thr.dec)
  );

  // Light-load thresholds
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ENTRY_MA <= 9'h000;
      EXIT_MA  <= 9'h000;
    end else begin
      ENTRY_MA <= thr.entry_ma;
      EXIT_MA  <= thr.exit_ma;
    end
  end

  // Phase add and drop thresholds
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ADD_MA  <= 13'h0000;
      DROP_MA <= 13'h0000;
    end else begin
      ADD_MA  <= thr.add_ma;
      DROP_MA <= thr.drop_ma;
    end
  end

  // ==========================================================
  // Read data
  buck_pkg::reg_byte_t rdata_next;

  always_comb begin
    unique case (REG_ADDR)
      `OFF_RESTORE:    rdata_next = restore_reg;
      `OFF_RAIL_DELAY: rdata_next = rail_delay_code_reg;
      `OFF_CHIP_IDENTIFICATION:    rdata_next = ID_WORD;
      `OFF_LIGHT_LOAD: rdata_next = light_load_reg;
      `OFF_PHASE:      rdata_next = phase_reg;
      `OFF_FLAGS:      rdata_next = flags_reg;
      default:         rdata_next = 8'h00;
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_next;
    end
  end
endmodule

// ===== rtl/step_tick.sv
// Prescaler making one pulse per delay step, restarted on each enable change
// Assumes CLK at the rate in buck_cfg.svh
`timescale 1ns/10ps
`include "buck_cfg.svh"
module step_tick #(
  parameter int STEP_CYCLES = `STEP_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic restart,
  output logic      tick
);
  if (STEP_CYCLES < 2 || STEP_CYCLES > 65535) begin : g_bad_step
    $error("STEP_CYCLES out of range");
  end
  logic [15:0] cnt_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 16'h0000;
    end else if (restart || tick) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  assign tick = (cnt_reg == 16'(STEP_CYCLES - 1));
endmodule

// ===== rtl/thr_decode.sv
// Decodes light-load and phase codes into milliamp thresholds
// Assumes codes are stable register outputs
`timescale 1ns/10ps
module thr_decode (
  thr_if.dec t
);
  // =====================================================
  // Code tables
  function automatic logic [8:0] entry_ma(input logic [2:0] c);
    case (c)
      3'h0: entry_ma = 9'd50;
      3'h1: entry_ma = 9'd75;
      3'h2: entry_ma = 9'd100;
      3'h3: entry_ma = 9'd125;
      3'h4: entry_ma = 9'd175;
      3'h5: entry_ma = 9'd200;
      3'h6: entry_ma = 9'd225;
      default: entry_ma = 9'd325;
    endcase
  endfunction
  function automatic logic [8:0] exit_ma(input logic [2:0] c);
    case (c)
      3'h0: exit_ma = 9'd100;
      3'h1: exit_ma = 9'd125;
      3'h2: exit_ma = 9'd150;
      3'h3: exit_ma = 9'd175;
      3'h4: exit_ma = 9'd225;
      3'h5: exit_ma = 9'd275;
      3'h6: exit_ma = 9'd325;
      default: exit_ma = 9'd375;
    endcase
  endfunction
  // Per-phase step 0.3 A plus 0.1 A per code, times active phases
  function automatic logic [12:0] phase_ma(input logic [2:0] c,
                                           input logic [2:0] n);
    logic [12:0] per;
    per = 13'h012c + 13'h0064 * {10'h000, c};
    phase_ma = per * {10'h000, n};
  endfunction
  assign t.entry_ma = entry_ma(t.entry_code);
  assign t.exit_ma  = exit_ma(t.exit_code);
  assign t.add_ma   = phase_ma(t.add_code, t.phases);
  assign t.drop_ma  = phase_ma(t.drop_code, t.phases);
endmodule

// ===== shared/buck_cfg.svh
// Register map, field layout, reset values and timing counts for the bank
// Assumes a 125 MHz core clock
`ifndef BUCK_CFG_SVH
`define BUCK_CFG_SVH
`define OFF_RESTORE      8'h11
`define OFF_RAIL_DELAY   8'h12
`define OFF_CHIP_IDENTIFICATION      8'h18
`define OFF_LIGHT_LOAD   8'h19
`define OFF_PHASE        8'h1f
`define OFF_FLAGS        8'h20
`define RST_RESTORE      8'h00
`define RST_RAIL_DELAY   8'h00
`define RST_LIGHT_LOAD   8'h05
`define RST_PHASE        8'h42
`define RESTORE_BIT      0
`define ENTRY_MSB        6
`define ENTRY_LSB        4
`define EXIT_MSB         2
`define EXIT_LSB         0
`define FIELD_MASK       8'h77
`define DELAY_NEVER      8'hff
`define CLK_PERIOD_PS    8000
`define STEP_US          100
`define STEP_CYCLES      ((`STEP_US * 1000000) / `CLK_PERIOD_PS)
`endif

// ===== shared/buck_pkg.sv
// Types shared by the register bank and its helpers
// Assumes buck_cfg.svh defines the numbers
package buck_pkg;
  typedef enum logic [1:0] {
    RAIL_OFF   = 2'b00,
    RAIL_WAKE  = 2'b01,
    RAIL_ON    = 2'b11,
    RAIL_SLEEP = 2'b10
  } rail_state_e;
  typedef logic [7:0] reg_byte_t;
endpackage

// ===== shared/thr_if.sv
// Threshold codes passed from the bank to the threshold decoder
// Assumes one clock domain
`timescale 1ns/10ps
interface thr_if;
  logic [2:0]  entry_code;
  logic [2:0]  exit_code;
  logic [2:0]  add_code;
  logic [2:0]  drop_code;
  logic [2:0]  phases;
  logic [8:0]  entry_ma;
  logic [8:0]  exit_ma;
  logic [12:0] add_ma;
  logic [12:0] drop_ma;
  modport bank (output entry_code, exit_code, add_code, drop_code, phases,
                input entry_ma, exit_ma, add_ma, drop_ma);
  modport dec  (input entry_code, exit_code, add_code, drop_code, phases,
                output entry_ma, exit_ma, add_ma, drop_ma);
endinterface

// ===== verification/buck_control_register_bank_tb_top.sv
// Self-checking bench for the control register bank
// Assumes the bank and its checker are compiled before it
`timescale 1ns/10ps
module buck_control_register_bank_tb_top;
  localparam logic       PC = 1'b0;   // Arbitrary value
  localparam logic [4:0] FV = 5'h13;  // Arbitrary value
  localparam logic [1:0] DR = 2'h1;   // Arbitrary value
  logic        CLK = 1'b0, ARST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic        RAIL_ENABLE_PIN = 1'b0, RAIL_ON;
  logic [7:0]  REG_ADDR = 8'h00, REG_WDATA = 8'h00, FAULT_SET = 8'h00;
  logic [7:0]  REG_RDATA, FAULT_FLAGS;
  logic [2:0]  ACTIVE_PHASES = 3'h3, c, pa, pd;
  logic [8:0]  ENTRY_MA, EXIT_MA;
  logic [12:0] ADD_MA, DROP_MA;
  logic [8:0]  ent [8] = '{9'h032, 9'h04b, 9'h064, 9'h07d,
                           9'h0af, 9'h0c8, 9'h0e1, 9'h145};
  logic [8:0]  ext [8] = '{9'h064, 9'h07d, 9'h096, 9'h0af,
                           9'h0e1, 9'h113, 9'h145, 9'h177};
  int          fails = 0, n_tests = 0;
  always #4 CLK = ~CLK;
  buck_ctrl_bank #(.STEP_CYCLES(10), .PART_CODE(PC), .FUSE_VER(FV),
    .SILICON_REVISION_FIELD(DR)) u_dut (.CLK, .ARST_N, .REG_WR, .REG_RD, .REG_ADDR,
    .REG_WDATA, .REG_RDATA, .RAIL_ENABLE_PIN, .ACTIVE_PHASES, .FAULT_SET,
    .FAULT_FLAGS, .RAIL_ON, .ENTRY_MA, .EXIT_MA, .ADD_MA, .DROP_MA);
  // ==========================================
  // Tasks
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: register %h, want %h", $time, g, e);
    end
  endtask
  task automatic chk_out(input logic [12:0] g, input logic [12:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: output %h, want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
    @(posedge CLK) REG_WR <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK) {REG_RD, REG_ADDR} <= {1'b1, a};
    @(posedge CLK) REG_RD <= 1'b0;
    #1 chk_reg(REG_RDATA, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wait_rail(input logic v);
    for (int i = 0; i < 8 && RAIL_ON !== v; i++) @(posedge CLK);
    #1 chk_out({12'h000, RAIL_ON}, {12'h000, v});
  endtask
  task automatic pin(input logic v);
    @(posedge CLK) RAIL_ENABLE_PIN <= v;
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
    rdc(8'h11, 8'h00);
    rdc(8'h19, 8'h05);
    rdc(8'h1f, 8'h42);
    wr(8'h18, 8'h55);
    rdc(8'h18, {PC, FV, DR});
    rdc(8'h30, 8'h00);
    wr(8'h19, 8'hff);
    rdc(8'h19, 8'h77);
    for (int i = 0; i < 8; i++) begin
      c  = 3'(i);
      pa = (i == 0) ? 3'h4 : c;
      pd = (i == 0) ? 3'h2 : c - 3'h1;
      wr(8'h19, {1'b0, c, 1'b0, c});
      if (i > 0) wr(8'h1f, {1'b0, pa, 1'b0, pd});
      cyc(3);
      chk_out({4'h0, ENTRY_MA}, {4'h0, ent[i]});
      chk_out({4'h0, EXIT_MA}, {4'h0, ext[i]});
      chk_out(ADD_MA, (13'h12c + 13'h064 * pa) * ACTIVE_PHASES);
      chk_out(DROP_MA, (13'h12c + 13'h064 * pd) * ACTIVE_PHASES);
    end
    @(posedge CLK) ACTIVE_PHASES <= 3'h7;
    cyc(3);
    chk_out(ADD_MA, 13'h1770);
    @(posedge CLK) ACTIVE_PHASES <= 3'h0;
    cyc(3);
    chk_out(DROP_MA, 13'h0384);
    wr(8'h12, 8'h02);
    pin(1'b1);
    cyc(20);
    chk_out({12'h000, RAIL_ON}, 13'h0000);
    wait_rail(1'b1);
    pin(1'b0);
    cyc(20);
    chk_out({12'h000, RAIL_ON}, 13'h0001);
    wait_rail(1'b0);
    pin(1'b1);
    cyc(12);
    pin(1'b0);
    pin(1'b1);
    cyc(20);
    chk_out({12'h000, RAIL_ON}, 13'h0000);
    wait_rail(1'b1);
    @(posedge CLK) FAULT_SET <= 8'h05;
    @(posedge CLK) FAULT_SET <= 8'h00;
    wr(8'h19, 8'h33);
    wr(8'h11, 8'h01);
    wr(8'h11, 8'h00);
    rdc(8'h12, 8'h00);
    rdc(8'h19, 8'h05);
    rdc(8'h11, 8'h00);
    chk_out({5'h00, FAULT_FLAGS}, 13'h0005);
    chk_out({12'h000, RAIL_ON}, 13'h0001);
    wr(8'h19, 8'h33);
    wr(8'h11, 8'h00);
    rdc(8'h19, 8'h33);
    rdc(8'h20, 8'h05);
    wr(8'h20, 8'h04);
    cyc(1);
    chk_out({5'h00, FAULT_FLAGS}, 13'h0004);
    wr(8'h12, 8'hff);
    cyc(1);
    chk_out({12'h000, RAIL_ON}, 13'h0000);
    pin(1'b0);
    cyc(5);
    pin(1'b1);
    cyc(40);
    chk_out({12'h000, RAIL_ON}, 13'h0000);
    tally_and_finish();
  end
endmodule

// ===== verification/buck_ctrl_bank_asserts.sv
// Port checker for the control register bank
// Assumes it is bound onto buck_ctrl_bank
`timescale 1ns/10ps
module buck_ctrl_bank_asserts #(
  parameter logic       PART_CODE = 1'b0,   // Arbitrary value
  parameter logic [4:0] FUSE_VER  = 5'h0a,  // Arbitrary value
  parameter logic [1:0] SILICON_REVISION_FIELD   = 2'h2    // Arbitrary value
) (
  input wire logic       CLK,
  input wire logic       ARST_N,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       RAIL_ENABLE_PIN,
  input wire logic [7:0] FAULT_SET,
  input wire logic [7:0] FAULT_FLAGS,
  input wire logic       RAIL_ON,
  input wire logic [8:0] ENTRY_MA,
  input wire logic [8:0] EXIT_MA
);
  // ==========================================
  // Helper state
  logic armed_reg;
  logic mapped;
  assign mapped = REG_ADDR inside {8'h11, 8'h12, 8'h18, 8'h19, 8'h1f, 8'h20};
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) armed_reg <= 1'b0;
    else if (REG_WR && REG_ADDR == 8'h11) armed_reg <= REG_WDATA[0];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ==========================================
  // Assertions
  a_id_read_only: assert property (REG_RD && REG_ADDR == 8'h18 |=>
    REG_RDATA == {PART_CODE, FUSE_VER, SILICON_REVISION_FIELD}) else $error("bad id");
  a_unmapped_zero: assert property (REG_RD && !mapped |=>
    REG_RDATA == 8'h00) else $error("unmapped read not zero");
  a_ones_power_down: assert property (REG_WR && REG_ADDR == 8'h12 &&
    REG_WDATA == 8'hff |-> ##[1:3] !RAIL_ON) else $error("no power down");
  a_rise_needs_pin: assert property ($rose(RAIL_ON) |->
    RAIL_ENABLE_PIN) else $error("rail on without enable");
  a_no_instant_on: assert property ($rose(RAIL_ENABLE_PIN) && !RAIL_ON
    |=> !RAIL_ON) else $error("rail on without delay");
  a_flag_sticky: assert property (|($past(FAULT_FLAGS) & ~FAULT_FLAGS) |->
    $past(REG_WR && REG_ADDR == 8'h20)) else $error("flag lost");
  a_flag_set: assert property (|FAULT_SET |=>
    (FAULT_FLAGS & $past(FAULT_SET)) == $past(FAULT_SET))
    else $error("flag not set");
  a_restore_reload: assert property (REG_WR && REG_ADDR == 8'h11 &&
    !REG_WDATA[0] && armed_reg |-> ##[1:3]
    (ENTRY_MA == 9'h032 && EXIT_MA == 9'h113)) else $error("no reload");
  a_exit_top: assert property (REG_WR && REG_ADDR == 8'h19 &&
    REG_WDATA[2:0] == 3'h7 |-> ##[1:3] EXIT_MA == 9'h177)
    else $error("exit code 7 wrong");
endmodule
bind buck_ctrl_bank buck_ctrl_bank_asserts #(.PART_CODE(PART_CODE),
  .FUSE_VER(FUSE_VER), .SILICON_REVISION_FIELD(SILICON_REVISION_FIELD)) u_chk (.CLK, .ARST_N, .REG_WR,
  .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .RAIL_ENABLE_PIN, .FAULT_SET,
  .FAULT_FLAGS, .RAIL_ON, .ENTRY_MA, .EXIT_MA);
